// ==== src/fan_pwm_range_and_ramp_control.v ====
// Fan drive block: span/rate and acoustic ramp registers, three drive channels
// How it works
// - Lock bit freezes span/rate and ramp registers; later writes are ignored.
// - Three-bit low rate select picks 11.0 to 88.2 Hz in low rate mode.
// - Bit 3 of a span register picks high (1) or low (0) drive rate.
// - Bits 7:4 select the temperature span, 2 to 80 degrees, default 32.
// - Remote-1 driven output ramps toward its target at the coded rate.
// - Ramp codes give steps 1,2,3,4,8,12,24,48; sweeps 146 to 3.4 ms.
// - Slow-scale bit stretches sweeps to 204 down to 4.8 ms.
// - Drive 1 slowdown bit makes its ramp four times slower; drives 2 and 3 do not ramp.
// - Remote-1 smoothing acts only while its enable bit is one.
// - Alignment bit one times speed inputs 2, 3, 4 to the third drive.
// - Alignment bit zero times only speed inputs 3 and 4 to it.
// - Below start temperature, floor-hold bit picks zero or minimum duty.
//
// Decided for this implementation: the plain strobed port.
`default_nettype none
`include "fan_pwm_map.vh"
module fan_pwm_range_and_ramp_control #(
    parameter integer RAMP_FAST = (`RAMP_FAST_MS * 1000000) / (`CLK_NS * 255) + 1,
    parameter integer RAMP_SLOW = (`RAMP_SLOW_MS * 1000000) / (`CLK_NS * 255) + 1,
    parameter integer LF_DIV0   = 44389
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_ce,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    input  wire [2:0] i_below_start,
    output reg  [7:0] o_rdata,
    output reg        o_fan_drive_1,
    output reg        o_fan_drive_2,
    output reg        o_fan_drive_3,
    output reg  [2:0] o_speed_sample_align,
    output reg        o_speed_window,
    output reg  [3:0] o_span_code_1,
    output reg  [3:0] o_span_code_2,
    output reg  [3:0] o_span_code_3
);
    reg  [7:0] span1_r;
    reg  [7:0] span2_r;
    reg  [7:0] span3_r;
    reg  [7:0] ramp1_r;
    reg  [7:0] ctrl_r;
    reg  [7:0] target1_r;
    reg  [7:0] target2_r;
    reg  [7:0] target3_r;
    reg  [7:0] floor_hold_select_1_r;
    reg  [7:0] floor_hold_select_2_r;
    reg  [7:0] floor_hold_select_3_r;
    reg  [2:0] below_s1_r;
    reg  [2:0] below_s2_r;
    reg  [7:0] rd_nxt;
    wire       locked;
    wire       wr_ok;
    wire [7:0] duty1;
    wire [7:0] duty2;
    wire [7:0] duty3;
    wire [2:0] pwm;
    wire [2:0] pstart;

    assign locked = ctrl_r[`C_LOCK];
    assign wr_ok  = i_wr && !locked;

    // Start-temperature comparisons come from outside this clock, so synchronise
    always @(posedge i_clk) begin
        if (i_srst) begin
            below_s1_r <= 3'h0;
            below_s2_r <= 3'h0;
        end else if (i_ce) begin
            below_s1_r <= i_below_start;
            below_s2_r <= below_s1_r;
        end
    end

    // Register writes; the lock can only be cleared by reset
    always @(posedge i_clk) begin
        if (i_srst) begin
            span1_r   <= `RST_SPAN;
            span2_r   <= `RST_SPAN;
            span3_r   <= `RST_SPAN;
            ramp1_r   <= `RST_RAMP;
            ctrl_r    <= `RST_CTRL;
            target1_r <= `RST_TARGET;
            target2_r <= `RST_TARGET;
            target3_r <= `RST_TARGET;
            floor_hold_select_1_r    <= `RST_MINDUTY;
            floor_hold_select_2_r    <= `RST_MINDUTY;
            floor_hold_select_3_r    <= `RST_MINDUTY;
        end else if (i_ce && i_wr) begin
            case (i_addr)
                `OFS_SPAN1:   if (wr_ok) span1_r <= i_wdata;
                `OFS_SPAN2:   if (wr_ok) span2_r <= i_wdata;
                `OFS_SPAN3:   if (wr_ok) span3_r <= i_wdata;
                `OFS_RAMP1:   if (wr_ok) ramp1_r <= i_wdata;
                `OFS_CTRL:    ctrl_r <= {i_wdata[7:1], i_wdata[0] | locked};
                `OFS_TARGET1: target1_r <= i_wdata;
                `OFS_TARGET2: target2_r <= i_wdata;
                `OFS_TARGET3: target3_r <= i_wdata;
                `OFS_MINDUTY1: floor_hold_select_1_r <= i_wdata;
                `OFS_MINDUTY2: floor_hold_select_2_r <= i_wdata;
                `OFS_MINDUTY3: floor_hold_select_3_r <= i_wdata;
                default: ;
            endcase
        end
    end

    // Read decode; unmapped addresses read zero
    always @* begin
        case (i_addr)
            `OFS_SPAN1:    rd_nxt = span1_r;
            `OFS_SPAN2:    rd_nxt = span2_r;
            `OFS_SPAN3:    rd_nxt = span3_r;
            `OFS_RAMP1:    rd_nxt = ramp1_r;
            `OFS_CTRL:     rd_nxt = ctrl_r;
            `OFS_STATUS:   rd_nxt = {2'b00, pwm, below_s2_r};
            `OFS_TARGET1:  rd_nxt = target1_r;
            `OFS_TARGET2:  rd_nxt = target2_r;
            `OFS_TARGET3:  rd_nxt = target3_r;
            `OFS_MINDUTY1: rd_nxt = floor_hold_select_1_r;
            `OFS_MINDUTY2: rd_nxt = floor_hold_select_2_r;
            `OFS_MINDUTY3: rd_nxt = floor_hold_select_3_r;
            `OFS_DUTY1:    rd_nxt = duty1;
            `OFS_DUTY2:    rd_nxt = duty2;
            `OFS_DUTY3:    rd_nxt = duty3;
            default:       rd_nxt = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge i_clk) begin
        if (i_srst)
            o_rdata <= 8'h00;
        else if (i_ce)
            o_rdata <= i_rd ? rd_nxt : 8'h00;
    end

    // Only drive 1 follows remote-1 here, so only it gets the ramp code
    fan_drive_channel #(
        .LF_DIV0   (LF_DIV0),
        .RAMP_FAST (RAMP_FAST),
        .RAMP_SLOW (RAMP_SLOW)
    ) u_ch1 (
        .i_clk          (i_clk),
        .i_srst         (i_srst),
        .i_ce           (i_ce),
        .i_span_reg     (span1_r),
        .i_target       (target1_r),
        .i_min_duty     (floor_hold_select_1_r),
        .i_below_start  (below_s2_r[0]),
        .i_floor_hold   (ramp1_r[`F_FLOOR1]),
        .i_smooth_en    (ramp1_r[`F_SMOOTH1]),
        .i_ramp_code    (ramp1_r[2:0]),
        .i_slow_scale   (ctrl_r[`C_SLOWSCALE]),
        .i_slow_x4      (ctrl_r[`C_SLOW_LO]),
        .o_duty         (duty1),
        .o_pwm          (pwm[0]),
        .o_period_start (pstart[0])
    );

    fan_drive_channel #(
        .LF_DIV0   (LF_DIV0),
        .RAMP_FAST (RAMP_FAST),
        .RAMP_SLOW (RAMP_SLOW)
    ) u_ch2 (
        .i_clk          (i_clk),
        .i_srst         (i_srst),
        .i_ce           (i_ce),
        .i_span_reg     (span2_r),
        .i_target       (target2_r),
        .i_min_duty     (floor_hold_select_2_r),
        .i_below_start  (below_s2_r[1]),
        .i_floor_hold   (ramp1_r[`F_FLOOR1 + 1]),
        .i_smooth_en    (1'b0),
        .i_ramp_code    (3'h0),
        .i_slow_scale   (ctrl_r[`C_SLOWSCALE]),
        .i_slow_x4      (ctrl_r[`C_SLOW_LO + 1]),
        .o_duty         (duty2),
        .o_pwm          (pwm[1]),
        .o_period_start (pstart[1])
    );

    fan_drive_channel #(
        .LF_DIV0   (LF_DIV0),
        .RAMP_FAST (RAMP_FAST),
        .RAMP_SLOW (RAMP_SLOW)
    ) u_ch3 (
        .i_clk          (i_clk),
        .i_srst         (i_srst),
        .i_ce           (i_ce),
        .i_span_reg     (span3_r),
        .i_target       (target3_r),
        .i_min_duty     (floor_hold_select_3_r),
        .i_below_start  (below_s2_r[2]),
        .i_floor_hold   (ramp1_r[`F_FLOOR1 + 2]),
        .i_smooth_en    (1'b0),
        .i_ramp_code    (3'h0),
        .i_slow_scale   (ctrl_r[`C_SLOWSCALE]),
        .i_slow_x4      (ctrl_r[`C_SLOW_LO + 2]),
        .o_duty         (duty3),
        .o_pwm          (pwm[2]),
        .o_period_start (pstart[2])
    );

    // Registered pin drives, span codes and speed-sense timing
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_fan_drive_1        <= 1'b0;
            o_fan_drive_2        <= 1'b0;
            o_fan_drive_3        <= 1'b0;
            o_speed_sample_align <= 3'h0;
            o_speed_window       <= 1'b0;
            o_span_code_1        <= 4'h0;
            o_span_code_2        <= 4'h0;
            o_span_code_3        <= 4'h0;
        end else if (i_ce) begin
            o_fan_drive_1 <= pwm[0];
            o_fan_drive_2 <= pwm[1];
            o_fan_drive_3 <= pwm[2];
            // Bit 0 = speed input 2, bit 1 = input 3, bit 2 = input 4
            o_speed_sample_align <= {2'b11, ramp1_r[`F_ALIGN]};
            // Sense only while drive 3 is high so shared fans are powered
            o_speed_window <= pwm[2] && !pstart[2];
            o_span_code_1 <= span1_r[`F_SPAN_HI:`F_SPAN_LO];
            o_span_code_2 <= span2_r[`F_SPAN_HI:`F_SPAN_LO];
            o_span_code_3 <= span3_r[`F_SPAN_HI:`F_SPAN_LO];
        end
    end
endmodule
`default_nettype wire

// ==== src/fan_pwm_map.vh ====
// Register offsets, field positions, reset values and timing figures for the fan drive block
`ifndef FAN_PWM_MAP_VH
`define FAN_PWM_MAP_VH
`define OFS_SPAN1        8'h5f
`define OFS_SPAN2        8'h60
`define OFS_SPAN3        8'h61
`define OFS_RAMP1        8'h62
`define OFS_CTRL         8'h70
`define OFS_STATUS       8'h71
`define OFS_TARGET1      8'h72
`define OFS_TARGET2      8'h73
`define OFS_TARGET3      8'h74
`define OFS_MINDUTY1     8'h75
`define OFS_MINDUTY2     8'h76
`define OFS_MINDUTY3     8'h77
`define OFS_DUTY1        8'h78
`define OFS_DUTY2        8'h79
`define OFS_DUTY3        8'h7a
`define RST_SPAN         8'hc4
`define RST_RAMP         8'h00
`define RST_CTRL         8'h00
`define RST_TARGET       8'hff
`define RST_MINDUTY      8'h80
`define F_MODE           3
`define F_SPAN_HI        7
`define F_SPAN_LO        4
`define F_SMOOTH1        3
`define F_ALIGN          4
`define F_FLOOR1         5
`define C_LOCK           0
`define C_SLOWSCALE      1
`define C_SLOW_LO        2
`define C_BELOW_LO       5
`define C_AUTO           0
`define HF_PERIOD_NS     40000
`define CLK_NS           8
`define HF_TICKS         (`HF_PERIOD_NS / `CLK_NS / 256)
`define RAMP_FAST_MS     146
`define RAMP_SLOW_MS     204
`endif

// ==== src/fan_drive_channel.v ====
// One fan drive channel: duty ramp limiter and PWM waveform generator
`default_nettype none
`include "fan_pwm_map.vh"
module fan_drive_channel #(
    parameter integer LF_DIV0   = 44389,
    parameter integer RAMP_FAST = 73000,
    parameter integer RAMP_SLOW = 102000
) (
    input  wire       i_clk,
    input  wire       i_srst,
    input  wire       i_ce,
    input  wire [7:0] i_span_reg,
    input  wire [7:0] i_target,
    input  wire [7:0] i_min_duty,
    input  wire       i_below_start,
    input  wire       i_floor_hold,
    input  wire       i_smooth_en,
    input  wire [2:0] i_ramp_code,
    input  wire       i_slow_scale,
    input  wire       i_slow_x4,
    output reg  [7:0] o_duty,
    output reg        o_pwm,
    output reg        o_period_start
);
    reg  [7:0]  duty_r;
    reg  [7:0]  phase_r;
    reg  [15:0] tick_r;
    reg  [19:0] ramp_cnt_r;
    reg  [7:0]  goal;
    reg  [7:0]  step;
    reg  [19:0] ramp_len;
    reg  [15:0] tick_len;
    reg  [8:0]  up_sum;
    reg  [7:0]  duty_nxt;

    // Rate divisors scale from the 11 Hz slot length, rounded to nearest, so a
    // short slot length in simulation keeps the same frequency ratios
    localparam integer LF_DIV1 = (LF_DIV0 * 110 + 73) / 147;
    localparam integer LF_DIV2 = (LF_DIV0 * 110 + 110) / 221;
    localparam integer LF_DIV3 = (LF_DIV0 * 110 + 147) / 294;
    localparam integer LF_DIV4 = (LF_DIV0 * 110 + 176) / 353;
    localparam integer LF_DIV5 = (LF_DIV0 * 110 + 220) / 441;
    localparam integer LF_DIV6 = (LF_DIV0 * 110 + 294) / 588;
    localparam integer LF_DIV7 = (LF_DIV0 * 110 + 441) / 882;
    localparam integer HF_LEN  = `HF_TICKS;

    // Below start temperature either stop the fan or hold its floor duty
    always @* begin
        if (i_below_start)
            goal = i_floor_hold ? i_min_duty : 8'h00;
        else
            goal = i_target;
    end

    // Step per update interval for each ramp code
    always @* begin
        case (i_ramp_code)
            3'h0: step = 8'h01;
            3'h1: step = 8'h02;
            3'h2: step = 8'h03;
            3'h3: step = 8'h04;
            3'h4: step = 8'h08;
            3'h5: step = 8'h0c;
            3'h6: step = 8'h18;
            default: step = 8'h30;
        endcase
    end

    // Interval chosen so 255 steps of one match the table sweep times
    always @* begin
        ramp_len = i_slow_scale ? RAMP_SLOW[19:0] : RAMP_FAST[19:0];
        if (i_slow_x4)
            ramp_len = {ramp_len[17:0], 2'b00};
    end

    // Low rate divides the 256-slot period; high rate uses a fixed short slot
    always @* begin
        if (i_span_reg[`F_MODE])
            tick_len = HF_LEN[15:0];
        else begin
            case (i_span_reg[2:0])
                3'h0: tick_len = LF_DIV0[15:0];
                3'h1: tick_len = LF_DIV1[15:0];
                3'h2: tick_len = LF_DIV2[15:0];
                3'h3: tick_len = LF_DIV3[15:0];
                3'h4: tick_len = LF_DIV4[15:0];
                3'h5: tick_len = LF_DIV5[15:0];
                3'h6: tick_len = LF_DIV6[15:0];
                default: tick_len = LF_DIV7[15:0];
            endcase
        end
    end

    // Rate-limited move toward the goal, or direct load when smoothing is off
    always @* begin
        up_sum = {1'b0, duty_r} + {1'b0, step};
        duty_nxt = duty_r;
        if (!i_smooth_en)
            duty_nxt = goal;
        else if (ramp_cnt_r == 20'h00000) begin
            if (goal > duty_r)
                duty_nxt = (up_sum[8] || up_sum[7:0] > goal) ? goal : up_sum[7:0];
            else if (goal < duty_r)
                duty_nxt = (duty_r - goal < step) ? goal : duty_r - step;
        end
    end

    // Ramp interval counter and duty register
    always @(posedge i_clk) begin
        if (i_srst) begin
            duty_r     <= 8'hff;
            ramp_cnt_r <= 20'h00000;
        end else if (i_ce) begin
            duty_r     <= duty_nxt;
            ramp_cnt_r <= (ramp_cnt_r == 20'h00000) ? ramp_len - 20'h00001 :
                          ramp_cnt_r - 20'h00001;
        end
    end

    // Waveform: high while phase is below duty; full duty keeps the pin high
    always @(posedge i_clk) begin
        if (i_srst) begin
            tick_r         <= 16'h0000;
            phase_r        <= 8'h00;
            o_pwm          <= 1'b0;
            o_duty         <= 8'hff;
            o_period_start <= 1'b0;
        end else if (i_ce) begin
            o_duty         <= duty_r;
            o_period_start <= 1'b0;
            if (tick_r >= tick_len - 16'h0001) begin
                tick_r  <= 16'h0000;
                phase_r <= phase_r + 8'h01;
                o_period_start <= (phase_r == 8'hff);
            end else
                tick_r <= tick_r + 16'h0001;
            o_pwm <= (duty_r == 8'hff) || (phase_r < duty_r);
        end
    end
endmodule
`default_nettype wire

// ==== verification/fan_pwm_monitor.sv ====
// Checker for the fan drive block register port and drive outputs
`default_nettype none
`include "fan_pwm_map.vh"
module fan_pwm_monitor (
    input wire logic       i_clk,
    input wire logic       i_srst,
    input wire logic       i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [2:0] i_below_start,
    input wire logic [7:0] o_rdata,
    input wire logic       o_fan_drive_2,
    input wire logic       o_fan_drive_3,
    input wire logic       o_speed_window,
    input wire logic [2:0] o_speed_sample_align,
    input wire logic [3:0] o_span_code_1,
    input wire logic [3:0] o_span_code_3
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FL_WAIT = 5000;
    logic [7:0]  sp1_r, sp3_r, rp_r;
    logic        lock_r;
    logic [1:0]  up_r;
    logic [13:0] fl_r;
    // Shadow registers; the lock freezes them exactly as it must freeze the block
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sp1_r  <= 8'hc4;
            sp3_r  <= 8'hc4;
            rp_r   <= 8'h00;
            lock_r <= 1'b0;
            up_r   <= 2'd0;
        end else begin
            up_r <= (up_r == 2'd3) ? up_r : up_r + 2'd1;
            if (i_ce && i_wr && i_addr == `OFS_CTRL && i_wdata[0])
                lock_r <= 1'b1;
            if (i_ce && i_wr && !lock_r && i_addr == `OFS_SPAN1)
                sp1_r <= i_wdata;
            if (i_ce && i_wr && !lock_r && i_addr == `OFS_SPAN3)
                sp3_r <= i_wdata;
            if (i_ce && i_wr && !lock_r && i_addr == `OFS_RAMP1)
                rp_r <= i_wdata;
        end
    end
    // Cycles that drive 2 has spent below start with a zero floor; long enough to cover a period
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_below_start[1] || rp_r[6])
            fl_r <= 14'h0000;
        else if (fl_r != 14'h3fff)
            fl_r <= fl_r + 14'h0001;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    sequence s_rd(logic [7:0] a);
        i_rd && i_ce && i_addr == a;
    endsequence
    property p_rd_idle; !(i_rd && i_ce) |=> o_rdata == 8'h00; endproperty
    property p_rd_unmapped; i_rd && i_ce && i_addr < `OFS_SPAN1 |=> o_rdata == 8'h00; endproperty
    property p_rd_span1; s_rd(`OFS_SPAN1) |=> o_rdata == $past(sp1_r); endproperty
    property p_rd_span3; s_rd(`OFS_SPAN3) |=> o_rdata == $past(sp3_r); endproperty
    property p_rd_ramp; s_rd(`OFS_RAMP1) |=> o_rdata == $past(rp_r); endproperty
    property p_code1; up_r == 2'd3 |-> o_span_code_1 == $past(sp1_r[7:4]); endproperty
    property p_code3; up_r == 2'd3 |-> o_span_code_3 == $past(sp3_r[7:4]); endproperty
    property p_align; up_r == 2'd3 |-> o_speed_sample_align == {2'b11, $past(rp_r[4])}; endproperty
    property p_floor; fl_r > FL_WAIT |-> !o_fan_drive_2; endproperty
    property p_window; o_speed_window |-> o_fan_drive_3; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    a_rd_span1: assert property (p_rd_span1) else $error("span 1 readback wrong");
    a_rd_span3: assert property (p_rd_span3) else $error("span 3 readback wrong");
    a_rd_ramp: assert property (p_rd_ramp) else $error("ramp readback wrong");
    a_code1: assert property (p_code1) else $error("span code 1 wrong");
    a_code3: assert property (p_code3) else $error("span code 3 wrong");
    a_align: assert property (p_align) else $error("speed alignment wrong");
    a_floor: assert property (p_floor) else $error("drive 2 not off below start");
    a_window: assert property (p_window) else $error("speed window outside drive 3 high");
endmodule
bind fan_pwm_range_and_ramp_control fan_pwm_monitor i_mon (.i_clk, .i_srst, .i_ce, .i_addr,
    .i_wdata, .i_wr, .i_rd, .i_below_start, .o_rdata, .o_fan_drive_2, .o_fan_drive_3,
    .o_speed_window, .o_speed_sample_align, .o_span_code_1, .o_span_code_3);
`default_nettype wire

// ==== verification/fan_model.sv ====
// Fan model: times the drive waveform between rising edges
`default_nettype none
module fan_model (
    input  wire logic        i_clk,
    input  wire logic        i_drive,
    output wire logic [15:0] o_period,
    output wire logic [7:0]  o_edges
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        last_r = 1'b0;
    logic [15:0] cnt_r = 16'h0000;
    logic [15:0] per_r = 16'h0000;
    logic [7:0]  ed_r = 8'h00;
    // A fan sees only edges, so the period is the gap between two rising ones
    always @(posedge i_clk) begin
        last_r <= i_drive;
        cnt_r  <= (i_drive && !last_r) ? 16'h0001 : cnt_r + 16'h0001;
        if (i_drive && !last_r) begin
            per_r <= cnt_r;
            ed_r  <= ed_r + 8'h01;
        end
    end
    assign o_period = per_r;
    assign o_edges  = ed_r;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Self-checking bench for the fan drive block
`default_nettype none
`include "fan_pwm_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam integer LFD = 16;
    // Ramp steps per code, and low rates in tenths of a hertz, code 0 in the low bits
    localparam [63:0] STEPS = {8'h30, 8'h18, 8'h0c, 8'h08, 8'h04, 8'h03, 8'h02, 8'h01};
    localparam [79:0] FREQS = {10'h372, 10'h24c, 10'h1b9, 10'h161, 10'h126, 10'h0dd,
                               10'h093, 10'h06e};
    logic        i_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_ce = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [2:0]  i_below_start = 3'b000;
    logic [7:0]  o_rdata, rd_v, edges;
    logic        drv2;
    logic [15:0] per;
    logic [31:0] seed = 32'hf8654639;
    integer      n_fail = 0;
    integer      checked = 0;
    integer      i, k;
    fan_pwm_range_and_ramp_control #(.RAMP_FAST(4), .RAMP_SLOW(6), .LF_DIV0(LFD)) i_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_below_start(i_below_start), .o_rdata(o_rdata),
        .o_fan_drive_1(), .o_fan_drive_2(drv2), .o_fan_drive_3(), .o_speed_sample_align(),
        .o_speed_window(), .o_span_code_1(), .o_span_code_2(), .o_span_code_3());
    fan_model i_fan (.i_clk(i_clk), .i_drive(drv2), .o_period(per), .o_edges(edges));
    // Free-running system clock
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Duty left after n ramp steps down from full scale
    function automatic integer exp_duty(input [2:0] c, input integer n);
        exp_duty = 255 - n * STEPS[c*8 +: 8];
        if (exp_duty < 0) exp_duty = 0;
    endfunction
    // Nominal low-rate period in clocks; frequencies held in tenths of a hertz
    function automatic integer lf_per(input [2:0] c);
        lf_per = 256 * LFD * 110 / FREQS[c*10 +: 10];
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 rd_v = o_rdata;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk(rd_v, e, e);
    endtask
    // Two rising edges after a change give one whole period of the new setting
    task automatic meas;
        logic [7:0] e0;
        e0 = edges;
        for (k = 0; k < 30000 && edges != e0 + 8'h02; k++) @(posedge i_clk);
    endtask
    // Smoothing off pins duty at full scale, then a ramp towards zero is sampled
    task automatic ramp_try(input logic [2:0] c, input logic [7:0] ctl, input integer w);
        wr(`OFS_RAMP1, 8'h00);
        wr(`OFS_TARGET1, 8'hff);
        repeat (8) @(posedge i_clk);
        wr(`OFS_CTRL, ctl);
        wr(`OFS_RAMP1, {5'b00001, c});
        wr(`OFS_TARGET1, 8'h00);
        repeat (w) @(posedge i_clk);
        rd(`OFS_DUTY1);
        chk(rd_v, exp_duty(c, 4), exp_duty(c, 2));
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Watchdog sized well above the expected run of about 48000 cycles
    initial begin
        repeat (95000) @(posedge i_clk);
        n_fail++;
        results();
    end
    initial begin
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        for (i = 0; i < 3; i++) chk_rd(`OFS_SPAN1 + i, 8'hc4);
        chk_rd(`OFS_RAMP1, 8'h00);
        chk_rd(8'h00, 8'h00);
        $display("test reset values done");
        for (i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            wr(`OFS_SPAN1 + seed[1:0], seed[15:8]);
            chk_rd(`OFS_SPAN1 + seed[1:0], seed[15:8]);
        end
        wr(8'h00, 8'h5a);
        chk_rd(8'h00, 8'h00);
        $display("test random registers done");
        // Full duty keeps the pin high with no edges, so give drive 2 a half duty
        wr(`OFS_TARGET2, 8'h80);
        wr(`OFS_SPAN2, 8'hcf);
        meas;
        chk(per, 256 * `HF_TICKS, 256 * `HF_TICKS);
        for (i = 0; i < 8; i++) begin
            wr(`OFS_SPAN2, 8'hc0 | i);
            meas;
            chk(per, lf_per(i) - lf_per(i) / 12, lf_per(i) + lf_per(i) / 12);
        end
        $display("test drive rates done");
        for (i = 0; i < 8; i++) ramp_try(i, 8'h00, 10);
        ramp_try(3'd1, 8'h02, 20);
        ramp_try(3'd1, 8'h04, 46);
        wr(`OFS_RAMP1, 8'h07);
        wr(`OFS_TARGET1, 8'h5a);
        repeat (6) @(posedge i_clk);
        chk_rd(`OFS_DUTY1, 8'h5a);
        $display("test ramp done");
        wr(`OFS_SPAN2, 8'hc4);
        wr(`OFS_RAMP1, 8'h00);
        @(posedge i_clk);
        i_below_start <= 3'b010;
        repeat (6000) @(posedge i_clk);
        rd(`OFS_STATUS);
        chk(rd_v & 8'h07, 8'h02, 8'h02);
        chk_rd(`OFS_DUTY2, 8'h00);
        wr(`OFS_RAMP1, 8'h40);
        repeat (6000) @(posedge i_clk);
        chk_rd(`OFS_DUTY2, `RST_MINDUTY);
        i_below_start <= 3'b000;
        $display("test floor hold done");
        wr(`OFS_SPAN1, 8'h3a);
        wr(`OFS_SPAN3, 8'h77);
        wr(`OFS_CTRL, 8'h01);
        for (i = 0; i < 4; i++) wr(`OFS_SPAN1 + i, 8'h00);
        chk_rd(`OFS_SPAN1, 8'h3a);
        chk_rd(`OFS_SPAN2, 8'hc4);
        chk_rd(`OFS_SPAN3, 8'h77);
        chk_rd(`OFS_RAMP1, 8'h40);
        wr(`OFS_TARGET2, 8'h11);
        chk_rd(`OFS_TARGET2, 8'h11);
        // A write while the clock enable is low must leave every register as it was
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(`OFS_TARGET2, 8'h22);
        i_ce <= 1'b1;
        chk_rd(`OFS_TARGET2, 8'h11);
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_srst <= 1'b0;
        chk_rd(`OFS_SPAN1, 8'hc4);
        wr(`OFS_SPAN1, 8'h5b);
        chk_rd(`OFS_SPAN1, 8'h5b);
        $display("test lock done");
        results();
    end
endmodule
`default_nettype wire
